// ==== hw/mele_pkg.sv ====
// Constants for the memory error log and machine-check routing block
package mele_pkg;
	localparam logic [7:0]  MELE_ENABLE_OFS   = 8'h7e;
	localparam logic [7:0]  MELE_LOG_OFS      = 8'h80;
	localparam logic [7:0]  MELE_ENABLE_RESET = 8'h00;
	localparam logic [7:0]  MELE_ENABLE_MASK  = 8'h0f;
	localparam logic [15:0] MELE_LOG_RESET    = 16'h0000;
	localparam int          MELE_BIT_TEST_B   = 15;
	localparam int          MELE_BIT_POISON_B = 14;
	localparam int          MELE_BIT_DED_B    = 13;
	localparam int          MELE_BIT_COPY_B   = 12;

	// Word hit on a 16-bit aligned configuration offset
	function automatic logic mele_hit(input logic [7:0] addr, input logic [7:0] ofs);
		mele_hit = (addr[7:1] == ofs[7:1]);
	endfunction : mele_hit
endpackage : mele_pkg

// ==== hw/mele_first_log.sv ====
// Sticky first-error log with write-one-to-clear bits
`timescale 1ns/1ps
`default_nettype none
module mele_first_log
	import mele_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        sticky_resetn_i,
	input  wire logic        ce_i,
	input  wire logic [15:0] event_i,
	input  wire logic [15:0] clear_i,
	output logic      [15:0] log_o,
	output logic      [15:0] next_event_o
);
	logic [15:0] next_log;
	logic [15:0] next_next_event;

	always_comb begin
		if (log_o == MELE_LOG_RESET) begin
			next_log        = event_i;
			next_next_event = 16'h0000;
		end else begin
			next_log        = log_o & ~clear_i;
			next_next_event = event_i;
		end
	end

	// Only the power-on reset touches the log, so ordinary reset keeps it
	always_ff @(posedge clock_i or negedge sticky_resetn_i) begin
		if (!sticky_resetn_i) begin
			log_o <= MELE_LOG_RESET;
		end else if (ce_i) begin
			log_o <= next_log;
		end
	end

	always_ff @(posedge clock_i or negedge sticky_resetn_i) begin
		if (!sticky_resetn_i) begin
			next_event_o <= 16'h0000;
		end else if (ce_i) begin
			next_event_o <= next_next_event;
		end else begin
			next_event_o <= 16'h0000;
		end
	end

	sequence log_empty_event_s;
		ce_i && log_o == 16'h0000 && event_i != 16'h0000;
	endsequence

	sequence log_busy_s;
		ce_i && log_o != 16'h0000;
	endsequence

	first_capture_a: assert property (@(posedge clock_i) disable iff (!sticky_resetn_i)
		log_empty_event_s |=> log_o == $past(event_i))
		else $error("first-error log did not latch all simultaneous events");

	no_new_bits_a: assert property (@(posedge clock_i) disable iff (!sticky_resetn_i)
		log_busy_s |=> (log_o & ~$past(log_o)) == 16'h0000)
		else $error("first-error log gained a bit while not empty");

	later_to_next_a: assert property (@(posedge clock_i) disable iff (!sticky_resetn_i)
		log_busy_s ##0 event_i != 16'h0000 |=> next_event_o == $past(event_i))
		else $error("later error not passed to next-error log");

	w1c_clear_a: assert property (@(posedge clock_i) disable iff (!sticky_resetn_i)
		log_busy_s |=> log_o == ($past(log_o) & ~$past(clear_i)))
		else $error("write-one-to-clear misbehaved");

	test_done_a: assert property (@(posedge clock_i) disable iff (!sticky_resetn_i)
		log_empty_event_s ##0 event_i[MELE_BIT_TEST_B] |=> log_o[MELE_BIT_TEST_B])
		else $error("test complete flag not set");

	poison_wr_a: assert property (@(posedge clock_i) disable iff (!sticky_resetn_i)
		log_empty_event_s ##0 event_i[MELE_BIT_POISON_B] |=> log_o[MELE_BIT_POISON_B])
		else $error("poisoned write flag not set");

	ded_retry_a: assert property (@(posedge clock_i) disable iff (!sticky_resetn_i)
		log_empty_event_s ##0 event_i[MELE_BIT_DED_B] |=> log_o[MELE_BIT_DED_B])
		else $error("retry flag not set");

	copy_done_a: assert property (@(posedge clock_i) disable iff (!sticky_resetn_i)
		log_empty_event_s ##0 event_i[MELE_BIT_COPY_B] |=> log_o[MELE_BIT_COPY_B])
		else $error("copy complete flag not set");
endmodule : mele_first_log
`default_nettype wire

// ==== hw/mele_top.sv ====
// Machine-check routing enable and DRAM first-error log, config-space access
// How it works
// - Enable bit 3 with buffer error flag 3 set in either log drives machine check.
// - Enable bit 2 with buffer error flag 2 set drives machine check, otherwise not.
// - Enable bit 1 with buffer error flag 1 set drives machine check, otherwise not.
// - Enable bit 0 with buffer error flag 0 set drives machine check, otherwise not.
// - The routing enable register is 8 bits, bits 3:0 read/write, bits 7:4 read as zero, and resets to zero.
// - The first-error log takes only the first error; later ones go to the next-error log.
// - While the log holds any bit, no new bit is set until software clears it.
// - All errors arriving in the cycle of the first error are latched together.
// - Log bits survive ordinary reset and clear only on a written one or on the sticky reset.
// - Bit 15 is set when channel B memory test completes.
// - Bit 14 is set on a poisoned write to channel B, whatever the ECC mode.
// - Bit 13 is set when a retry after double error detect starts on channel B.
// - Bit 12 is set when channel B sparing or mirroring data copy completes.
`timescale 1ns/1ps
`default_nettype none
module mele_top
	import mele_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        resetn_i,
	input  wire logic        sticky_resetn_i,
	input  wire logic        ce_i,
	input  wire logic [7:0]  cfg_addr_i,
	input  wire logic        cfg_wr_i,
	input  wire logic        cfg_rd_i,
	input  wire logic [1:0]  cfg_be_i,
	input  wire logic [15:0] cfg_wdata_i,
	output logic      [15:0] cfg_rdata_o,
	input  wire logic [3:0]  buffer_first_error_log_i,
	input  wire logic [3:0]  buffer_next_error_log_i,
	input  wire logic [15:0] dram_event_i,
	output logic      [15:0] dram_first_error_log_o,
	output logic      [15:0] dram_next_event_o,
	output logic             machine_check_error_out_n_o
);
	logic [7:0]  buffer_machine_check_enable;
	logic [15:0] log_clear;
	logic [15:0] next_rdata;
	logic        next_mc_n;
	logic        wr_en_hit;
	logic        wr_log_hit;
	logic [3:0]  buffer_flags;

	assign wr_en_hit  = ce_i && cfg_wr_i && mele_hit(cfg_addr_i, MELE_ENABLE_OFS);
	assign wr_log_hit = ce_i && cfg_wr_i && mele_hit(cfg_addr_i, MELE_LOG_OFS);

	// Flags from both logs route alike, so they are merged once for the checks
	assign buffer_flags = buffer_first_error_log_i | buffer_next_error_log_i;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			buffer_machine_check_enable <= MELE_ENABLE_RESET;
		end else if (wr_en_hit && cfg_be_i[0]) begin
			buffer_machine_check_enable <= cfg_wdata_i[7:0] & MELE_ENABLE_MASK;
		end
	end

	// Only lanes that are enabled may clear log bits
	assign log_clear = wr_log_hit ? (cfg_wdata_i & {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}})
	                              : 16'h0000;

	mele_first_log u_first_log (
		.clock_i         (clock_i),
		.sticky_resetn_i (sticky_resetn_i),
		.ce_i            (ce_i),
		.event_i         (dram_event_i),
		.clear_i         (log_clear),
		.log_o           (dram_first_error_log_o),
		.next_event_o    (dram_next_event_o)
	);

	assign next_mc_n = ~|(buffer_machine_check_enable[3:0]
	                   & (buffer_first_error_log_i | buffer_next_error_log_i));

	// Registered so the pin never glitches while flags and enables change together
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			machine_check_error_out_n_o <= 1'b1;
		end else if (ce_i) begin
			machine_check_error_out_n_o <= next_mc_n;
		end
	end

	always_comb begin
		next_rdata = 16'h0000;
		if (mele_hit(cfg_addr_i, MELE_ENABLE_OFS)) begin
			next_rdata = {8'h00, buffer_machine_check_enable};
		end else if (mele_hit(cfg_addr_i, MELE_LOG_OFS)) begin
			next_rdata = dram_first_error_log_o;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_rdata_o <= 16'h0000;
		end else if (ce_i && cfg_rd_i) begin
			cfg_rdata_o <= next_rdata;
		end
	end

	sequence mc_cause_s;
		ce_i && |(buffer_machine_check_enable[3:0]
		          & (buffer_first_error_log_i | buffer_next_error_log_i));
	endsequence

	mc_assert_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		mc_cause_s |=> !machine_check_error_out_n_o)
		else $error("machine check not asserted for enabled flag");

	mc_quiet_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		ce_i && buffer_machine_check_enable[3:0] == 4'h0 |=> machine_check_error_out_n_o)
		else $error("machine check asserted with all enables off");

	mc_bit1_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		ce_i && buffer_machine_check_enable[3:0] == 4'h2 && buffer_first_error_log_i[1]
		|=> !machine_check_error_out_n_o)
		else $error("flag 1 not routed");

	mc_bit0_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		ce_i && buffer_machine_check_enable[3:0] == 4'h1 && !buffer_first_error_log_i[0]
		&& !buffer_next_error_log_i[0] |=> machine_check_error_out_n_o)
		else $error("flag 0 routed without cause");

	enable_reset_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		$rose(resetn_i) |-> buffer_machine_check_enable == MELE_ENABLE_RESET)
		else $error("enable register not zero after reset");

	enable_write_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		wr_en_hit && cfg_be_i[0] |=> buffer_machine_check_enable[3:0] == $past(cfg_wdata_i[3:0]))
		else $error("enable register write lost");

	reserved_zero_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		ce_i && cfg_rd_i && mele_hit(cfg_addr_i, MELE_ENABLE_OFS) |=> cfg_rdata_o[15:4] == 12'h000)
		else $error("reserved enable bits read nonzero");

	sequence mc_idle_s;
		ce_i && ~|(buffer_machine_check_enable[3:0] & buffer_flags);
	endsequence

	sequence enable_read_s;
		ce_i && cfg_rd_i && mele_hit(cfg_addr_i, MELE_ENABLE_OFS);
	endsequence

	sequence log_read_s;
		ce_i && cfg_rd_i && mele_hit(cfg_addr_i, MELE_LOG_OFS);
	endsequence

	sequence busy_clear_s;
		wr_log_hit && dram_first_error_log_o != MELE_LOG_RESET;
	endsequence

	mc_bit3_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		ce_i && buffer_machine_check_enable[3] && buffer_flags[3]
		|=> !machine_check_error_out_n_o)
		else $error("flag 3 not routed");

	mc_bit2_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		ce_i && buffer_machine_check_enable[2] && buffer_flags[2]
		|=> !machine_check_error_out_n_o)
		else $error("flag 2 not routed");

	mc_next_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		ce_i && |(buffer_machine_check_enable[3:0] & buffer_next_error_log_i)
		|=> !machine_check_error_out_n_o)
		else $error("next-log flag not routed");

	mc_idle_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		mc_idle_s |=> machine_check_error_out_n_o)
		else $error("machine check asserted without an enabled flag");

	mc_bit3_off_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		mc_idle_s ##0 buffer_flags[3] |=> machine_check_error_out_n_o)
		else $error("flag 3 routed while disabled");

	mc_bit2_off_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		mc_idle_s ##0 buffer_flags[2] |=> machine_check_error_out_n_o)
		else $error("flag 2 routed while disabled");

	mc_bit1_off_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		mc_idle_s ##0 buffer_flags[1] |=> machine_check_error_out_n_o)
		else $error("flag 1 routed while disabled");

	mc_bit0_off_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		mc_idle_s ##0 buffer_flags[0] |=> machine_check_error_out_n_o)
		else $error("flag 0 routed while disabled");

	mc_reset_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		$rose(resetn_i) |-> machine_check_error_out_n_o && cfg_rdata_o == 16'h0000)
		else $error("pin or read data not idle after reset");

	// Clock enable low must leave every register where it was, except the next-event output, which clears
	mc_hold_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		!ce_i |=> $stable(machine_check_error_out_n_o))
		else $error("machine check moved while clock enable low");

	enable_hold_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		!ce_i |=> $stable(buffer_machine_check_enable))
		else $error("enable register moved while clock enable low");

	enable_lane_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		wr_en_hit && !cfg_be_i[0] |=> $stable(buffer_machine_check_enable))
		else $error("enable register written with its lane off");

	enable_rsvd_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		buffer_machine_check_enable[7:4] == 4'h0)
		else $error("reserved enable bits hold a one");

	enable_read_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		enable_read_s |=> cfg_rdata_o == {8'h00, $past(buffer_machine_check_enable)})
		else $error("enable register read wrong");

	log_read_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		log_read_s |=> cfg_rdata_o == $past(dram_first_error_log_o))
		else $error("first-error log read wrong");

	unmapped_read_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		ce_i && cfg_rd_i && !mele_hit(cfg_addr_i, MELE_ENABLE_OFS)
		&& !mele_hit(cfg_addr_i, MELE_LOG_OFS) |=> cfg_rdata_o == 16'h0000)
		else $error("unmapped offset read nonzero");

	rdata_hold_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		!(ce_i && cfg_rd_i) |=> $stable(cfg_rdata_o))
		else $error("read data moved without a read");

	log_lane_clear_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		busy_clear_s ##0 !cfg_be_i[1]
		|=> dram_first_error_log_o[15:8] == $past(dram_first_error_log_o[15:8]))
		else $error("log upper byte cleared with its lane off");

	log_zero_write_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		busy_clear_s ##0 cfg_wdata_i == 16'h0000
		|=> dram_first_error_log_o == $past(dram_first_error_log_o))
		else $error("writing zero changed the log");
endmodule : mele_top
`default_nettype wire

// ==== tb/mele_cpu_model.sv ====
// Processor-side model that counts cycles of machine check seen
`timescale 1ns/1ps
`default_nettype none
module mele_cpu_model (
	input  wire logic        clock_i,
	input  wire logic        resetn_i,
	input  wire logic        mc_n_i,
	output logic      [15:0] hits_o
);
	// Samples the pin at the edge like a bus agent; cleared with ordinary reset
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) hits_o <= 16'h0;
		else hits_o <= hits_o + {15'h0, !mc_n_i};
	end
endmodule : mele_cpu_model
`default_nettype wire

// ==== tb/mele_top_tb.sv ====
// Self-checking bench for the error log and machine-check routing
`timescale 1ns/1ps
`default_nettype none
module mele_top_tb;
	logic        clock_i = 1'b0, resetn_i = 1'b0, sresetn = 1'b0, ce = 1'b1;
	logic        wr = 1'b0, rd = 1'b0, mc_n, m_mc = 1'b1;
	logic [1:0]  be = 2'h0;
	logic [7:0]  addr = 8'h0, m_en = 8'h0;
	logic [3:0]  bf = 4'h0, bn = 4'h0;
	logic [15:0] wd = 16'h0, ev = 16'h0, rdata, log, nxt, hits;
	logic [15:0] m_rd = 16'h0, m_log = 16'h0, m_nxt = 16'h0, m_hits = 16'h0;
	int          mismatches = 0, n_checks = 0, seed = 23857, i, r;
	always #20 clock_i = ~clock_i;
	mele_top dut (.clock_i, .resetn_i, .sticky_resetn_i(sresetn), .ce_i(ce),
		.cfg_addr_i(addr), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_be_i(be),
		.cfg_wdata_i(wd), .cfg_rdata_o(rdata), .buffer_first_error_log_i(bf),
		.buffer_next_error_log_i(bn), .dram_event_i(ev), .dram_first_error_log_o(log),
		.dram_next_event_o(nxt), .machine_check_error_out_n_o(mc_n));
	mele_cpu_model cpu (.clock_i, .resetn_i, .mc_n_i(mc_n), .hits_o(hits));
	// Reference model; reads see the values from before the edge
	always @(posedge clock_i) begin
		m_hits = resetn_i ? m_hits + {15'h0, !m_mc} : 16'h0;
		if (!resetn_i) begin
			{m_en, m_rd, m_mc} = {8'h0, 16'h0, 1'b1};
		end else if (ce) begin
			if (rd) m_rd = addr[7:1] == 7'h3f ? {8'h0, m_en} : addr[7:1] == 7'h40 ? m_log : 16'h0;
			m_mc = ~|(m_en[3:0] & (bf | bn));
			if (wr && be[0] && addr[7:1] == 7'h3f) m_en = {4'h0, wd[3:0]};
		end
		if (!sresetn) {m_log, m_nxt} = 32'h0;
		else if (!ce || !resetn_i) m_nxt = 16'h0;
		else if (m_log == 16'h0) {m_log, m_nxt} = {ev, 16'h0};
		else begin
			m_nxt = ev;
			if (wr && addr[7:1] == 7'h40) m_log = m_log & ~(wd & {{8{be[1]}}, {8{be[0]}}});
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	always @(negedge clock_i) if (resetn_i && sresetn) begin
		chk("read data", m_rd, rdata);
		chk("first log", m_log, log);
		chk("next events", m_nxt, nxt);
		chk("machine check", {15'h0, m_mc}, {15'h0, mc_n});
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#2;
	endtask : cyc
	task automatic acc(input logic w, input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
		{wr, rd, addr, be, wd} = {w, !w, a, b, d};
		cyc(1);
		{wr, rd} = 2'h0;
		// One idle edge so a following call never reassigns a strobe in the same step
		cyc(1);
	endtask : acc
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : finish_test
	initial begin
		cyc(16);
		{resetn_i, sresetn} = 2'h3;
		acc(1'b0, 8'h7e, 2'h3, 16'h0);
		acc(1'b0, 8'h80, 2'h3, 16'h0);
		acc(1'b1, 8'h7e, 2'h3, 16'hffff);
		acc(1'b0, 8'h7f, 2'h3, 16'h0);
		acc(1'b0, 8'h10, 2'h3, 16'h0);
		for (i = 0; i < 4; i++) begin
			acc(1'b1, 8'h7e, 2'h1, 16'h1 << i);
			bf = 4'hf ^ (4'h1 << i);
			cyc(2);
			{bf, bn} = {4'h1 << i, 4'h0};
			cyc(2);
			{bf, bn} = {4'h0, 4'h1 << i};
			cyc(2);
			bn = 4'h0;
		end
		for (i = 12; i < 16; i++) begin
			ev = 16'h1 << i;
			cyc(1);
			ev = 16'h1 << (27 - i);
			cyc(1);
			ev = 16'h0;
			acc(1'b1, 8'h80, 2'h3, 16'h0);
			acc(1'b1, 8'h80, 2'h2, 16'hffff);
		end
		ev = 16'hf000;
		cyc(1);
		ev = 16'h0;
		acc(1'b1, 8'h7e, 2'h1, 16'h000f);
		resetn_i = 1'b0;
		cyc(2);
		resetn_i = 1'b1;
		acc(1'b0, 8'h80, 2'h3, 16'h0);
		acc(1'b0, 8'h7e, 2'h3, 16'h0);
		// Random traffic with clock enable gaps and sparse events
		for (i = 0; i < 400; i++) begin
			r = $random(seed);
			{ce, wr, rd, be, bf, bn} = r[12:0];
			addr = r[13] ? 8'h80 : 8'h7e;
			wd = 16'($random(seed));
			ev = 16'($random(seed) & $random(seed) & $random(seed));
			cyc(1);
		end
		{ce, wr, rd, bf, bn, ev} = {1'b1, 26'h0};
		cyc(2);
		chk("hit count", m_hits, hits);
		finish_test();
	end
endmodule : mele_top_tb
`default_nettype wire
